// ==== dv/asu_remote_uart.sv ====
// Remote serial partner: decodes frames from the unit and sends frames to it.
module asu_remote_uart #(
   parameter int BIT_CLKS = 8
) (
   input wire logic ref_clk,
   input wire logic lineIn,
   output logic lineOut,
   input wire logic [1:0] parSel,
   input wire logic eightBits,
   output logic frameValid,
   output logic [9:0] frameWord
);
   timeunit 1ns;
   timeprecision 1ps;
   // Word being assembled: stop sample, parity sample, character bits.
   logic [9:0] rxWord;

   // Idle level of our own line is high, and nothing is reported yet.
   initial
   begin
      lineOut = 1'b1;
      frameValid = 1'b0;
      frameWord = 10'h000;
   end

   // Receiver: a low sample opens a frame, then each bit is taken mid-cell.
   always
   begin
      @(posedge ref_clk);
      if (lineIn === 1'b0)
      begin
         repeat (BIT_CLKS / 2) @(posedge ref_clk);
         rxWord = 10'h000;
         for (int i = 0; i < (eightBits ? 8 : 7); i++)
         begin
            repeat (BIT_CLKS) @(posedge ref_clk);
            rxWord[i] = lineIn;
         end
         // Parity cell exists for every selection except none.
         if (parSel != asu_pkg::PAR_NONE)
         begin
            repeat (BIT_CLKS) @(posedge ref_clk);
            rxWord[8] = lineIn;
         end
         repeat (BIT_CLKS) @(posedge ref_clk);
         rxWord[9] = lineIn;
         frameWord <= rxWord;
         frameValid <= 1'b1;
         @(posedge ref_clk);
         frameValid <= 1'b0;
      end
   end

   // Sends one frame; flipPar corrupts the parity cell on purpose.
   task automatic send_frame(input logic [7:0] data, input logic flipPar, input int stops);
      logic par;
      par = ^(data & (eightBits ? 8'hff : 8'h7f));
      if (parSel == asu_pkg::PAR_ODD)
         par = ~par;
      if (parSel == asu_pkg::PAR_ZERO)
         par = 1'b0;
      @(posedge ref_clk);
      lineOut <= 1'b0;
      repeat (BIT_CLKS) @(posedge ref_clk);
      for (int i = 0; i < (eightBits ? 8 : 7); i++)
      begin
         lineOut <= data[i];
         repeat (BIT_CLKS) @(posedge ref_clk);
      end
      if (parSel != asu_pkg::PAR_NONE)
      begin
         lineOut <= par ^ flipPar;
         repeat (BIT_CLKS) @(posedge ref_clk);
      end
      lineOut <= 1'b1;
      repeat (BIT_CLKS * stops) @(posedge ref_clk);
   endtask

   // Holds the line at a fixed level, used to show the input is ignored.
   task automatic drive_level(input logic lvl);
      @(posedge ref_clk);
      lineOut <= lvl;
   endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the asynchronous serial unit.
`define CHK(what, expv, gotv) \
   begin \
      comparisons++; \
      if ((gotv) !== (expv)) \
      begin \
         mismatches++; \
         $display("Error %s expected %h seen %h", what, expv, gotv); \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // Bit length in clocks; the smallest divisor keeps the run short.
   localparam int K = 8;
   // A read note: what was read, the expected value and the bits that count.
   typedef struct {string name; logic [7:0] expv; logic [7:0] mask;} asu_note_type;
   logic ref_clk;
   logic reset_n;
   logic [15:0] regAddr;
   logic [7:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [7:0] regRdData;
   logic serialInPin;
   logic serialOutPin;
   logic serialOutEn;
   logic txBusy;
   logic rxDone;
   logic [1:0] parSel;
   logic eightBits;
   logic frameValid;
   logic [9:0] frameWord;
   logic rdPending = 1'b0;
   int mismatches = 0;
   int comparisons = 0;
   int busyCount = 0;
   int rxDoneCount = 0;
   int rxTarget = 0;
   int busyExp;
   logic [9:0] frameExp;
   asu_note_type rdNote;
   asu_note_type rdQ[$];
   int busyQ[$];
   logic [9:0] frameQ[$];
   // The serial line has a pull-up, so a released output reads high.
   wire logic lineToRemote;
   assign lineToRemote = serialOutEn ? serialOutPin : 1'b1;

   // Free-running clock of 20 ns.
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   asu_serial_unit uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
      .txBusy(txBusy), .rxDone(rxDone)
   );

   asu_remote_uart #(.BIT_CLKS(K)) remote (
      .ref_clk(ref_clk), .lineIn(lineToRemote), .lineOut(serialInPin), .parSel(parSel),
      .eightBits(eightBits), .frameValid(frameValid), .frameWord(frameWord)
   );

   // Watcher: read data, frame length on txBusy and decoded line frames.
   always @(posedge ref_clk)
   begin
      if (rdPending)
      begin
         rdNote = rdQ.pop_front();
         `CHK(rdNote.name, rdNote.expv & rdNote.mask, regRdData & rdNote.mask)
      end
      rdPending <= regRead;
      if (rxDone === 1'b1)
         rxDoneCount++;
      if (txBusy === 1'b1)
         busyCount <= busyCount + 1;
      else if (busyCount != 0)
      begin
         // Aborted frames push no note, so only noted frames are judged.
         if (busyQ.size() > 0)
         begin
            busyExp = busyQ.pop_front();
            `CHK("frame length", busyExp, busyCount)
         end
         busyCount <= 0;
      end
      if (frameValid === 1'b1 && frameQ.size() > 0)
      begin
         frameExp = frameQ.pop_front();
         `CHK("line frame", frameExp, frameWord)
      end
   end

   // Write: one strobe cycle, then one idle cycle before the next access.
   task automatic reg_wr(input logic [15:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      regAddr <= addr;
      regWrData <= data;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask

   // Read: the note is queued with the strobe and judged by the watcher.
   task automatic reg_rd(input logic [15:0] addr, input logic [7:0] expv,
                         input logic [7:0] mask, input string name);
      @(posedge ref_clk);
      regAddr <= addr;
      regRead <= 1'b1;
      rdQ.push_back('{name, expv, mask});
      @(posedge ref_clk);
      regRead <= 1'b0;
   endtask

   // Bounded wait for the next receive completion.
   task automatic wait_rx();
      rxTarget++;
      for (int i = 0; i < 20 * K && rxDoneCount < rxTarget; i++)
         @(posedge ref_clk);
      `CHK("receive count", rxTarget, rxDoneCount)
   endtask

   // One format: a frame each way at once, then buffer and status read back.
   task automatic run_config(input logic [1:0] par, input logic eight, input logic two);
      logic [7:0] fmt;
      logic [7:0] txd;
      logic [7:0] rxd;
      logic [7:0] mask;
      logic flip;
      logic expPar;
      fmt = {3'b000, par, eight, two, 1'b1};
      txd = 8'($urandom);
      rxd = 8'($urandom);
      flip = 1'($urandom);
      mask = eight ? 8'hff : 8'h7f;
      expPar = par[1] ? (^(txd & mask) ^ ~par[0]) : 1'b0;
      parSel = par;
      eightBits = eight;
      reg_wr(asu_pkg::MODE_ADDR, fmt | 8'h80);
      reg_wr(asu_pkg::MODE_ADDR, fmt | 8'he0);
      repeat (2) @(posedge ref_clk);
      busyQ.push_back((2 + (eight ? 8 : 7) + (par != 2'h0) + two) * K);
      frameQ.push_back({1'b1, expPar, txd & mask});
      fork
         reg_wr(asu_pkg::TXDATA_ADDR, txd);
         remote.send_frame(rxd, flip, 1);
      join
      wait_rx();
      for (int i = 0; i < 4 * K && txBusy !== 1'b0; i++)
         @(posedge ref_clk);
      reg_rd(asu_pkg::RXDATA_ADDR, rxd & mask, 8'hff, "receive data");
      reg_rd(asu_pkg::ERR_ADDR, {5'h00, flip & par[1], 2'b00}, 8'hff, "errors");
   endtask

   // Closing verdict, shared by the main sequence and the watchdog.
   task automatic report_and_stop();
      if (mismatches == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      void'($urandom(32'hd07ef340));
      reset_n = 1'b0;
      regAddr = 16'h0000;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      parSel = 2'h0;
      eightBits = 1'b1;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      reg_rd(asu_pkg::MODE_ADDR, 8'h01, 8'hff, "mode reset");
      reg_rd(16'hff7f, 8'h00, 8'hff, "unmapped");
      // Stop mode: the output pin follows the port latch and direction.
      reg_wr(asu_pkg::PORT_ADDR, 8'h0c);
      @(posedge ref_clk);
      `CHK("port pin low", 2'b01, {serialOutPin, serialOutEn})
      reg_wr(asu_pkg::PORT_ADDR, 8'h0d);
      @(posedge ref_clk);
      `CHK("port pin high", 2'b11, {serialOutPin, serialOutEn})
      // A low input while powered off must look idle and start nothing.
      remote.drive_level(1'b0);
      repeat (3 * K) @(posedge ref_clk);
      reg_rd(asu_pkg::PORT_ADDR, 8'h10, 8'h10, "input view");
      remote.drive_level(1'b1);
      `CHK("stop mode receive", 0, rxDoneCount)
      repeat (12 * K) @(posedge ref_clk);
      reg_wr(asu_pkg::BAUD_ADDR, 8'h08);
      for (int cfg = 0; cfg < 16; cfg++)
         run_config(2'(cfg >> 2), cfg[1], cfg[0]);
      // Clearing transmit enable mid-frame stops it and returns the pin.
      reg_wr(asu_pkg::MODE_ADDR, 8'he5);
      reg_wr(asu_pkg::TXDATA_ADDR, 8'h5a);
      repeat (3 * K) @(posedge ref_clk);
      reg_wr(asu_pkg::MODE_ADDR, 8'ha5);
      // The frame sequencer clears on the edge after the mode write lands.
      repeat (2) @(posedge ref_clk);
      `CHK("abort busy and pin", 2'b01, {txBusy, serialOutPin})
      repeat (12 * K) @(posedge ref_clk);
      // A parity error is wiped when reception is disabled.
      parSel = 2'h3;
      eightBits = 1'b1;
      reg_wr(asu_pkg::MODE_ADDR, 8'hbd);
      remote.send_frame(8'h33, 1'b1, 1);
      wait_rx();
      reg_wr(asu_pkg::MODE_ADDR, 8'h9d);
      reg_rd(asu_pkg::ERR_ADDR, 8'h00, 8'hff, "errors after rx off");
      // Receive disable clears the receive buffer, and power off keeps it clear.
      reg_wr(asu_pkg::MODE_ADDR, 8'hbd);
      remote.send_frame(8'hc3, 1'b0, 1);
      wait_rx();
      reg_wr(asu_pkg::MODE_ADDR, 8'h9d);
      reg_wr(asu_pkg::MODE_ADDR, 8'h1d);
      reg_rd(asu_pkg::RXDATA_ADDR, 8'h00, 8'hff, "buffer after power off");
      reg_rd(asu_pkg::MODE_ADDR, 8'h1d, 8'hff, "mode readback");
      repeat (4) @(posedge ref_clk);
      report_and_stop();
   end

   // Watchdog: the whole sequence needs well under this many cycles.
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      report_and_stop();
   end
endmodule

// ==== logic/asu_baud_tick.sv ====
// Baud tick generator: one tick each time the divisor count wraps.
module asu_baud_tick #(
   parameter int DIV_W = 5
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);
   // Counter runs only while enabled and restarts from zero when stopped.
   logic [DIV_W-1:0] count_r;
   logic [DIV_W-1:0] last;
   assign last = (divisor < asu_pkg::DIV_MIN) ? asu_pkg::DIV_MIN - 5'h01 : divisor - 5'h01;

   // Count up and wrap at the divisor; a stopped counter holds zero.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_r <= '0;
      end
      else if (!run || count_r == last)
      begin
         count_r <= '0;
      end
      else
      begin
         count_r <= count_r + 1'b1;
      end
   end

   // Tick marks the final count of each period.
   assign tick = run && (count_r == last);
endmodule

// ==== logic/asu_parity.sv ====
// Parity calculator over 7 or 8 character bits.
module asu_parity (
   input wire logic [7:0] data,
   input wire logic eightBits,
   input wire logic [1:0] parSel,
   output logic parBit
);
   logic ones;
   // Bit 7 joins the count only for 8-bit characters.
   assign ones = ^data[6:0] ^ (eightBits & data[7]);
   // Even: bit makes ones count even; odd: makes it odd; zero: always 0.
   always_comb
   begin
      case (parSel)
         asu_pkg::PAR_EVEN: parBit = ones;
         asu_pkg::PAR_ODD: parBit = ~ones;
         default: parBit = 1'b0;
      endcase
   end
endmodule

// ==== logic/asu_pkg.sv ====
// Package of constants and types for the asynchronous serial unit.
package asu_pkg;
   // Register byte addresses on the plain register port.
   localparam logic [15:0] MODE_ADDR = 16'hff70;
   localparam logic [15:0] BAUD_ADDR = 16'hff71;
   localparam logic [15:0] TXDATA_ADDR = 16'hff72;
   localparam logic [15:0] ERR_ADDR = 16'hff73;
   localparam logic [15:0] RXDATA_ADDR = 16'hff74;
   localparam logic [15:0] PORT_ADDR = 16'hff75;
   // Reset values.
   localparam logic [7:0] MODE_RESET = 8'h01;
   localparam logic [7:0] BAUD_RESET = 8'h1f;
   localparam logic [7:0] PORT_RESET = 8'h0f;
   // Mode register field positions.
   localparam int POWER_BIT = 7;
   localparam int TXEN_BIT = 6;
   localparam int RXEN_BIT = 5;
   localparam int PARHI_BIT = 4;
   localparam int PARLO_BIT = 3;
   localparam int CHLEN_BIT = 2;
   localparam int STOPLEN_BIT = 1;
   localparam int FIXED_BIT = 0;
   // Baud register fields: divisor in bits 4..0.
   localparam int DIV_MSB = 4;
   // Port register bit positions: out latch, out direction, in latch, in direction.
   localparam int OUTLAT_BIT = 0;
   localparam int OUTDIR_BIT = 1;
   localparam int INLAT_BIT = 2;
   localparam int INDIR_BIT = 3;
   // Error status bit positions.
   localparam int PERR_BIT = 2;
   localparam int FERR_BIT = 1;
   localparam int OVR_BIT = 0;
   // Minimum divisor value; smaller settings are clamped.
   localparam logic [4:0] DIV_MIN = 5'h08;
   // Parity selections taken from the two parity select bits.
   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_ZERO = 2'h1,
      PAR_ODD = 2'h2,
      PAR_EVEN = 2'h3
   } asu_parity_type;
   // Shared serial engine states, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_START = 5'h02,
      ST_DATA = 5'h04,
      ST_PAR = 5'h08,
      ST_STOP = 5'h10
   } asu_state_type;
endpackage

// ==== logic/asu_serial_unit.sv ====
// Asynchronous serial unit: mode control, frame format, parity, pin takeover.
// Operation
// - All enables clear means stop mode.
// - Mode register resets to 01H.
// - Power off resets unit, clock held.
// - Transmit enable clear resets transmitter.
// - Receive enable clear resets receiver.
// - Power off forces serial input high.
// - Pins are ports in stop mode; here only the output pin, input view reads high.
// - One byte per frame, full duplex.
// - One start bit, 7/8 bits LSB first.
// - Transmitter sends one or two stops.
// - Parity even, odd, zero or none.
// - Format comes from mode bits 4..1.
// - Even parity bit makes ones even.
// - Even parity error on odd count.
// - Odd parity bit makes ones odd.
// - Odd parity error on even count.
// - Zero parity sends 0, never errors.
// - No parity omits bit, never errors.
// - Receiver checks one stop bit only.
module asu_serial_unit (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic serialInPin,
   output logic serialOutPin,
   output logic serialOutEn,
   output logic txBusy,
   output logic rxDone
);
   // Software-visible registers.
   logic [7:0] modeCtl_r;
   logic [7:0] baudCtl_r;
   logic [7:0] portCtl_r;
   logic [2:0] errStat_r;
   logic [7:0] rxBuf_r;
   logic rxFull_r;
   logic [7:0] rdData_r;
   // Decoded mode bits.
   logic powerOn, txOn, rxOn, eightBits, twoStops;
   logic [1:0] parSel;
   assign powerOn = modeCtl_r[asu_pkg::POWER_BIT];
   assign txOn = powerOn && modeCtl_r[asu_pkg::TXEN_BIT];
   assign rxOn = powerOn && modeCtl_r[asu_pkg::RXEN_BIT];
   assign parSel = modeCtl_r[asu_pkg::PARHI_BIT:asu_pkg::PARLO_BIT];
   assign eightBits = modeCtl_r[asu_pkg::CHLEN_BIT];
   assign twoStops = modeCtl_r[asu_pkg::STOPLEN_BIT];

   // Address match used by both write and read paths.
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction

   // Mode, baud and port registers; writes land one cycle after the strobe.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         modeCtl_r <= asu_pkg::MODE_RESET;
         baudCtl_r <= asu_pkg::BAUD_RESET;
         portCtl_r <= asu_pkg::PORT_RESET;
      end
      else if (regWrite)
      begin
         if (hit(regAddr, asu_pkg::MODE_ADDR))
         begin
            // Bit 0 is kept at one whatever software writes.
            modeCtl_r <= {regWrData[7:1], 1'b1};
         end
         else if (hit(regAddr, asu_pkg::BAUD_ADDR))
         begin
            baudCtl_r <= regWrData;
         end
         else if (hit(regAddr, asu_pkg::PORT_ADDR))
         begin
            portCtl_r <= {4'h0, regWrData[3:0]};
         end
      end
   end

   // Internal view of the input pin is forced idle while powered down.
   logic rxLine;
   assign rxLine = powerOn ? serialInPin : 1'b1;

   // Transmitter: own baud tick, state and shift register.
   asu_pkg::asu_state_type txState_r;
   logic [7:0] txShift_r;
   logic [2:0] txCount_r;
   logic txStop2_r;
   logic txPar_r;
   logic txLine_r;
   logic txTick, txParBit, txLoad;
   assign txLoad = regWrite && hit(regAddr, asu_pkg::TXDATA_ADDR) && txOn;

   asu_baud_tick #(.DIV_W(5)) txBaud (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(txOn && txState_r != asu_pkg::ST_IDLE),
      .divisor(baudCtl_r[asu_pkg::DIV_MSB:0]),
      .tick(txTick)
   );

   asu_parity txParGen (
      .data(regWrData),
      .eightBits(eightBits),
      .parSel(parSel),
      .parBit(txParBit)
   );

   // Transmit frame sequencer; cleared whenever transmission is disabled.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txState_r <= asu_pkg::ST_IDLE;
         txShift_r <= '0;
         txCount_r <= '0;
         txStop2_r <= 1'b0;
         txPar_r <= 1'b0;
         txLine_r <= 1'b1;
      end
      else if (!txOn)
      begin
         txState_r <= asu_pkg::ST_IDLE;
         txShift_r <= '0;
         txCount_r <= '0;
         txLine_r <= 1'b1;
      end
      else
      begin
         case (txState_r)
            asu_pkg::ST_IDLE:
            begin
               if (txLoad)
               begin
                  txShift_r <= regWrData;
                  txPar_r <= txParBit;
                  txCount_r <= '0;
                  txLine_r <= 1'b0;
                  txState_r <= asu_pkg::ST_START;
               end
            end
            asu_pkg::ST_START:
            begin
               if (txTick)
               begin
                  txLine_r <= txShift_r[0];
                  txState_r <= asu_pkg::ST_DATA;
               end
            end
            asu_pkg::ST_DATA:
            begin
               if (txTick)
               begin
                  if (txCount_r == (eightBits ? 3'h7 : 3'h6))
                  begin
                     if (parSel == asu_pkg::PAR_NONE)
                     begin
                        txLine_r <= 1'b1;
                        txStop2_r <= twoStops;
                        txState_r <= asu_pkg::ST_STOP;
                     end
                     else
                     begin
                        txLine_r <= txPar_r;
                        txState_r <= asu_pkg::ST_PAR;
                     end
                  end
                  else
                  begin
                     txCount_r <= txCount_r + 3'h1;
                     txShift_r <= {1'b0, txShift_r[7:1]};
                     txLine_r <= txShift_r[1];
                  end
               end
            end
            asu_pkg::ST_PAR:
            begin
               if (txTick)
               begin
                  txLine_r <= 1'b1;
                  txStop2_r <= twoStops;
                  txState_r <= asu_pkg::ST_STOP;
               end
            end
            default:
            begin
               if (txTick)
               begin
                  if (txStop2_r)
                  begin
                     txStop2_r <= 1'b0;
                  end
                  else
                  begin
                     txState_r <= asu_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Pin takeover: serial data while transmission is enabled, port latch otherwise.
   assign serialOutPin = txOn ? txLine_r : portCtl_r[asu_pkg::OUTLAT_BIT];
   assign serialOutEn = txOn | ~portCtl_r[asu_pkg::OUTDIR_BIT];
   assign txBusy = (txState_r != asu_pkg::ST_IDLE);

   // Receiver; runs independently of the transmitter for full duplex.
   asu_pkg::asu_state_type rxState_r;
   logic [7:0] rxShift_r;
   logic [2:0] rxCount_r;
   logic rxPar_r;
   logic rxDone_r;
   logic rxTick, rxExpPar, rxPerr;
   // Half a bit time is waited after the falling edge, so that bits are taken mid-cell.
   // Without it every sample would land on a cell boundary and read the next bit.
   logic [4:0] rxHalf_r;
   logic [4:0] rxHalfLast;
   assign rxHalfLast = ((baudCtl_r[asu_pkg::DIV_MSB:0] < asu_pkg::DIV_MIN) ? asu_pkg::DIV_MIN
                        : baudCtl_r[asu_pkg::DIV_MSB:0]) >> 1;
   asu_baud_tick #(.DIV_W(5)) rxBaud (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(rxOn && rxState_r != asu_pkg::ST_IDLE && rxState_r != asu_pkg::ST_START),
      .divisor(baudCtl_r[asu_pkg::DIV_MSB:0]),
      .tick(rxTick)
   );
   asu_parity rxParChk (
      .data(rxShift_r),
      .eightBits(eightBits),
      .parSel(parSel),
      .parBit(rxExpPar)
   );
   // Only even and odd modes can flag; mismatch equals wrong ones count.
   assign rxPerr = parSel[1] && (rxPar_r != rxExpPar);

   // Receive frame sequencer; ticks sample each bit one period after the previous sample.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rxState_r <= asu_pkg::ST_IDLE;
         rxShift_r <= '0;
         rxCount_r <= '0;
         rxPar_r <= 1'b0;
         rxDone_r <= 1'b0;
         rxHalf_r <= '0;
      end
      else if (!rxOn)
      begin
         rxState_r <= asu_pkg::ST_IDLE;
         rxHalf_r <= '0;
         rxShift_r <= '0;
         rxCount_r <= '0;
         rxDone_r <= 1'b0;
      end
      else
      begin
         rxDone_r <= 1'b0;
         case (rxState_r)
            asu_pkg::ST_IDLE:
            begin
               rxHalf_r <= '0;
               if (!rxLine)
               begin
                  rxState_r <= asu_pkg::ST_START;
               end
            end
            asu_pkg::ST_START:
            begin
               // The bit timer starts from mid-cell once half a bit has passed.
               rxHalf_r <= rxHalf_r + 5'h01;
               if (rxHalf_r == rxHalfLast)
               begin
                  rxCount_r <= '0;
                  rxShift_r <= '0;
                  rxState_r <= asu_pkg::ST_DATA;
               end
            end
            asu_pkg::ST_DATA:
            begin
               if (rxTick)
               begin
                  // LSB arrives first and settles at bit 0 after shifting.
                  rxShift_r <= eightBits ? {rxLine, rxShift_r[7:1]}
                                         : {1'b0, rxLine, rxShift_r[6:1]};
                  if (rxCount_r == (eightBits ? 3'h7 : 3'h6))
                  begin
                     rxState_r <= (parSel == asu_pkg::PAR_NONE) ? asu_pkg::ST_STOP
                                                                : asu_pkg::ST_PAR;
                  end
                  else
                  begin
                     rxCount_r <= rxCount_r + 3'h1;
                  end
               end
            end
            asu_pkg::ST_PAR:
            begin
               if (rxTick)
               begin
                  rxPar_r <= rxLine;
                  rxState_r <= asu_pkg::ST_STOP;
               end
            end
            default:
            begin
               // Only the first stop bit is checked.
               if (rxTick)
               begin
                  rxDone_r <= 1'b1;
                  rxState_r <= asu_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end
   assign rxDone = rxDone_r;

   // Stop bit level at the completion tick, needed for framing status.
   logic rxStopOk_r;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rxStopOk_r <= 1'b1;
      end
      else if (rxTick && rxState_r == asu_pkg::ST_STOP)
      begin
         rxStopOk_r <= rxLine;
      end
   end

   // Receive buffer and error status; new errors win over a read clear.
   logic errRead, bufRead;
   assign errRead = regRead && hit(regAddr, asu_pkg::ERR_ADDR);
   assign bufRead = regRead && hit(regAddr, asu_pkg::RXDATA_ADDR);
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         errStat_r <= '0;
         rxBuf_r <= '0;
         rxFull_r <= 1'b0;
      end
      else if (!rxOn)
      begin
         errStat_r <= '0;
         rxBuf_r <= '0;
         rxFull_r <= 1'b0;
      end
      else if (rxDone_r)
      begin
         errStat_r[asu_pkg::PERR_BIT] <= rxPerr | (errStat_r[asu_pkg::PERR_BIT] & ~errRead);
         errStat_r[asu_pkg::FERR_BIT] <= ~rxStopOk_r | (errStat_r[asu_pkg::FERR_BIT] & ~errRead);
         errStat_r[asu_pkg::OVR_BIT] <= (rxFull_r & ~bufRead)
                                        | (errStat_r[asu_pkg::OVR_BIT] & ~errRead);
         if (!rxFull_r || bufRead)
         begin
            rxBuf_r <= rxShift_r;
            rxFull_r <= 1'b1;
         end
      end
      else
      begin
         if (errRead)
         begin
            errStat_r <= '0;
         end
         if (bufRead)
         begin
            rxFull_r <= 1'b0;
         end
      end
   end

   // Read data register; valid the cycle after the read strobe only.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdData_r <= '0;
      end
      else if (!regRead)
      begin
         rdData_r <= '0;
      end
      else if (hit(regAddr, asu_pkg::MODE_ADDR))
      begin
         rdData_r <= modeCtl_r;
      end
      else if (hit(regAddr, asu_pkg::BAUD_ADDR))
      begin
         rdData_r <= baudCtl_r;
      end
      else if (hit(regAddr, asu_pkg::ERR_ADDR))
      begin
         rdData_r <= {5'h00, errStat_r};
      end
      else if (hit(regAddr, asu_pkg::RXDATA_ADDR))
      begin
         rdData_r <= rxBuf_r;
      end
      else if (hit(regAddr, asu_pkg::PORT_ADDR))
      begin
         rdData_r <= {txBusy, rxFull_r, 1'b0, rxLine, portCtl_r[3:0]};
      end
      else
      begin
         rdData_r <= '0;
      end
   end
   assign regRdData = rdData_r;

   // Stop mode holds both engines idle.
   sequence s_stopped;
      !txBusy && rxState_r == asu_pkg::ST_IDLE;
   endsequence
   a_stop_mode_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !powerOn |=> s_stopped)
      else $error("engines not idle in stop mode");
   a_mode_bit0_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
      modeCtl_r[asu_pkg::FIXED_BIT])
      else $error("mode bit 0 not one");
   a_power_off_line: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !powerOn |-> rxLine)
      else $error("input view not high when off");
   a_tx_disable_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !txOn |=> !txBusy && txLine_r)
      else $error("transmitter not reset");
   a_rx_disable_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !rxOn |=> errStat_r == 3'h0 && !rxFull_r)
      else $error("receiver not reset");
   a_port_out_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !txOn |-> serialOutPin == portCtl_r[asu_pkg::OUTLAT_BIT])
      else $error("port pin not given back");
   a_start_bit_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
      txLoad && !txBusy |=> serialOutPin == 1'b0 && txState_r == asu_pkg::ST_START)
      else $error("start bit missing");
   a_parity_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
      rxDone_r && !parSel[1] |=> !errStat_r[asu_pkg::PERR_BIT]
      || $past(errStat_r[asu_pkg::PERR_BIT] && !errRead))
      else $error("parity error in zero or none mode");
endmodule
